// *** hdl/lvdc_pkg.sv ***
// Package with register map, field positions and carrier types.
package lvdc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] LVDC_OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] LVDC_OFS_CTRL_TWO = 4'h4;

    localparam logic [7:0] LVDC_RST_CTRL_ONE = 8'h1C;
    localparam logic [7:0] LVDC_RST_CTRL_TWO = 8'h00;

    // ------------------------------------------------------------------
    // Field positions, control one
    // ------------------------------------------------------------------
    localparam int LVDC_B_WARN_FLAG     = 7;
    localparam int LVDC_B_WARN_ACK      = 6;
    localparam int LVDC_B_WARN_IRQ_EN   = 5;
    localparam int LVDC_B_RESET_EN      = 4;
    localparam int LVDC_B_STOP_EN       = 3;
    localparam int LVDC_B_DETECT_EN     = 2;
    localparam int LVDC_B_BUF_DRIVE     = 1;
    localparam int LVDC_B_BUF_EN        = 0;

    // ------------------------------------------------------------------
    // Field positions, control two
    // ------------------------------------------------------------------
    localparam int LVDC_B_TRIP_SEL      = 6;
    localparam int LVDC_B_WARN_LVL_HI   = 5;
    localparam int LVDC_B_WARN_LVL_LO   = 4;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       warning_flag;
        logic       warning_irq_enable;
        logic       detect_reset_enable;
        logic       detect_stop_enable;
        logic       detect_enable;
        logic       ref_buffer_drive_select;
        logic       ref_buffer_enable;
        logic       detect_trip_select;
        logic [1:0] warning_level_select;
        logic       wr_reset_en;
        logic       wr_detect_en;
        logic       wr_trip_sel;
        logic       ack;
        logic [7:0] rdata;
    } lvdc_state_t;

    typedef struct packed {
        logic       detect_on;
        logic       trip_high;
        logic [1:0] warn_level;
        logic       buf_on;
        logic       buf_high_drive;
    } lvdc_analog_ctl_t;

endpackage : lvdc_pkg

// *** hdl/lvdc_top.sv ***
// Supply monitor control and status registers on a Wishbone slave.
// Operation
// - Warning flag with interrupt enable set raises the interrupt request.
// - Detect-reset enable takes first write after reset only.
// - Detect-reset enable set turns an enabled detect event into reset.
// - Stop-enable is read/write; keeps detection alive in stop mode.
// - Detect enable is write-once and qualifies the detect-reset, stop-enable and warning set; trip select and warning level reach analog_ctl ungated.
// - Buffer drive select picks high or low drive when buffer on.
// - Buffer enable switches the reference buffer on or off.
// - Control two bit 7 and low reserved bits always read zero.
// - Trip select is write-once; 0 low, 1 high trip point.
// - Two-bit warning level field selects one of four trip points.
// - Acknowledge write clears warning flag only if condition is gone.
// - Warning condition with detection enabled sets the warning flag.
// - Stop mode disables detection unless stop-enable or debug enable.
module lvdc_top (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [3:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      warning_condition,
    input  wire logic                      detect_event,
    input  wire logic                      stop_mode,
    input  wire logic                      background_debug_enable,
    output logic                           warning_irq,
    output logic                           detect_reset_req,
    output lvdc_pkg::lvdc_analog_ctl_t     analog_ctl
);

    lvdc_pkg::lvdc_state_t st;
    lvdc_pkg::lvdc_state_t next_st;

    logic       req;
    logic       wr_one;
    logic       wr_two;
    logic       rd_hit;
    logic       detect_live;
    logic [7:0] wbyte;
    logic [7:0] reg_one;
    logic [7:0] reg_two;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Only byte lane 0 carries register data; upper lanes read zero.
    assign req    = wb_cyc_i & wb_stb_i & ~st.ack;
    assign wbyte  = wb_dat_i[7:0];
    assign wr_one = req & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == lvdc_pkg::LVDC_OFS_CTRL_ONE);
    assign wr_two = req & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == lvdc_pkg::LVDC_OFS_CTRL_TWO);
    assign rd_hit = req & ~wb_we_i;

    // ------------------------------------------------------------------
    // Detector qualification
    // ------------------------------------------------------------------
    // Detection runs while enabled, except in stop mode without a keeper.
    assign detect_live = st.detect_enable
                         & (~stop_mode | st.detect_stop_enable
                            | background_debug_enable);

    assign reg_one = {st.warning_flag, 1'b0, st.warning_irq_enable,
                      st.detect_reset_enable, st.detect_stop_enable,
                      st.detect_enable, st.ref_buffer_drive_select,
                      st.ref_buffer_enable};
    assign reg_two = {1'b0, st.detect_trip_select,
                      st.warning_level_select, 4'h0};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st     = st;
        next_st.ack = req;
        if (rd_hit) begin
            case (wb_adr_i)
                lvdc_pkg::LVDC_OFS_CTRL_ONE: next_st.rdata = reg_one;
                lvdc_pkg::LVDC_OFS_CTRL_TWO: next_st.rdata = reg_two;
                default:                     next_st.rdata = 8'h00;
            endcase
        end
        if (wr_one) begin
            next_st.warning_irq_enable =
                wbyte[lvdc_pkg::LVDC_B_WARN_IRQ_EN];
            next_st.detect_stop_enable =
                wbyte[lvdc_pkg::LVDC_B_STOP_EN];
            next_st.ref_buffer_drive_select =
                wbyte[lvdc_pkg::LVDC_B_BUF_DRIVE];
            next_st.ref_buffer_enable =
                wbyte[lvdc_pkg::LVDC_B_BUF_EN];
            if (!st.wr_reset_en) begin
                next_st.detect_reset_enable =
                    wbyte[lvdc_pkg::LVDC_B_RESET_EN];
                next_st.wr_reset_en = 1'b1;
            end
            if (!st.wr_detect_en) begin
                next_st.detect_enable =
                    wbyte[lvdc_pkg::LVDC_B_DETECT_EN];
                next_st.wr_detect_en = 1'b1;
            end
            if (wbyte[lvdc_pkg::LVDC_B_WARN_ACK] && !warning_condition) begin
                next_st.warning_flag = 1'b0;
            end
        end
        if (wr_two) begin
            next_st.warning_level_select =
                wbyte[lvdc_pkg::LVDC_B_WARN_LVL_HI:
                      lvdc_pkg::LVDC_B_WARN_LVL_LO];
            if (!st.wr_trip_sel) begin
                next_st.detect_trip_select =
                    wbyte[lvdc_pkg::LVDC_B_TRIP_SEL];
                next_st.wr_trip_sel = 1'b1;
            end
        end
        // A set in the same cycle as an acknowledge wins over the clear.
        if (warning_condition && detect_live) begin
            next_st.warning_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st                         <= '0;
            st.detect_reset_enable     <=
                lvdc_pkg::LVDC_RST_CTRL_ONE[lvdc_pkg::LVDC_B_RESET_EN];
            st.detect_stop_enable      <=
                lvdc_pkg::LVDC_RST_CTRL_ONE[lvdc_pkg::LVDC_B_STOP_EN];
            st.detect_enable           <=
                lvdc_pkg::LVDC_RST_CTRL_ONE[lvdc_pkg::LVDC_B_DETECT_EN];
            st.detect_trip_select      <=
                lvdc_pkg::LVDC_RST_CTRL_TWO[lvdc_pkg::LVDC_B_TRIP_SEL];
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o    = st.ack;
    assign wb_dat_o    = {24'h000000, st.rdata};
    assign warning_irq = st.warning_flag & st.warning_irq_enable;
    // Reset request follows the detector directly so a collapse is not delayed.
    assign detect_reset_req = detect_event & detect_live
                              & st.detect_reset_enable;

    assign analog_ctl.detect_on      = detect_live;
    assign analog_ctl.trip_high      = st.detect_trip_select;
    assign analog_ctl.warn_level     = st.warning_level_select;
    assign analog_ctl.buf_on         = st.ref_buffer_enable;
    assign analog_ctl.buf_high_drive = st.ref_buffer_enable
                                       & st.ref_buffer_drive_select;

endmodule : lvdc_top

// *** tb/low_voltage_detect_control_bench.sv ***
// Self-checking bench for the supply monitor control block.
module low_voltage_detect_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        warning_condition, detect_event, stop_mode, warning_irq;
    logic        background_debug_enable, detect_reset_req;
    lvdc_pkg::lvdc_analog_ctl_t analog_ctl;
    int          mismatches = 0, checks = 0, cycles = 0;
    lvdc_top uut (
        .clk                     (clk),
        .rst_b                   (rst_b),
        .wb_cyc_i                (wb_cyc_i),
        .wb_stb_i                (wb_stb_i),
        .wb_we_i                 (wb_we_i),
        .wb_adr_i                (wb_adr_i),
        .wb_sel_i                (wb_sel_i),
        .wb_dat_i                (wb_dat_i),
        .wb_dat_o                (wb_dat_o),
        .wb_ack_o                (wb_ack_o),
        .warning_condition       (warning_condition),
        .detect_event            (detect_event),
        .stop_mode               (stop_mode),
        .background_debug_enable (background_debug_enable),
        .warning_irq             (warning_irq),
        .detect_reset_req        (detect_reset_req),
        .analog_ctl              (analog_ctl)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // A hung handshake must still end in the closing report.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        wb_dat_i <= {24'h000000, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rd
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic reset_dut;
        @(posedge clk) rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
    endtask : reset_dut
    task automatic t_warning;
        rd(4'h0, lvdc_pkg::LVDC_RST_CTRL_ONE);
        rd(4'h8, 8'h00);
        wr(4'h0, 8'h3C);
        @(posedge clk) warning_condition <= 1'b1;
        settle;
        chk(warning_irq, 1'b1);
        wr(4'h0, 8'h7C);
        rd(4'h0, 8'hBC);
        @(posedge clk) warning_condition <= 1'b0;
        wr(4'h0, 8'h7C);
        rd(4'h0, 8'h3C);
        wr(4'h0, 8'h1C);
        @(posedge clk) warning_condition <= 1'b1;
        settle;
        chk(warning_irq, 1'b0);
        rd(4'h0, 8'h9C);
        @(posedge clk) warning_condition <= 1'b0;
        wr(4'h0, 8'h5C);
    endtask : t_warning
    task automatic t_detect;
        @(posedge clk) detect_event <= 1'b1;
        settle;
        chk(detect_reset_req, 1'b1);
        @(posedge clk) stop_mode <= 1'b1;
        settle;
        chk(analog_ctl.detect_on, 1'b1);
        wr(4'h0, 8'h00);
        settle;
        chk(detect_reset_req, 1'b0);
        rd(4'h0, 8'h14);
        @(posedge clk) background_debug_enable <= 1'b1;
        settle;
        chk(analog_ctl.detect_on, 1'b1);
    endtask : t_detect
    task automatic t_disabled;
        wr(4'h0, 8'h03);
        rd(4'h0, 8'h03);
        chk(analog_ctl.buf_high_drive, 1'b1);
        @(posedge clk) warning_condition <= 1'b1;
        settle;
        chk(detect_reset_req, 1'b0);
        wr(4'h0, 8'h3E);
        rd(4'h0, 8'h2A);
        chk(analog_ctl.buf_on, 1'b0);
    endtask : t_disabled
    task automatic t_ctrl_two;
        rd(4'h4, lvdc_pkg::LVDC_RST_CTRL_TWO);
        wr(4'h4, 8'hFF);
        rd(4'h4, 8'h70);
        chk(analog_ctl.trip_high, 1'b1);
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(4'h4, {2'b00, 2'(i), 4'h0});
            rd(4'h4, {2'b01, 2'(i), 4'h0});
            chk({6'h00, analog_ctl.warn_level}, 8'(i));
        end
    endtask : t_ctrl_two
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = 8'h00;
        {warning_condition, detect_event, stop_mode} = 3'h0;
        background_debug_enable = 1'b0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        reset_dut;
        t_warning;
        t_detect;
        reset_dut;
        t_disabled;
        t_ctrl_two;
        wrap_up;
    end
endmodule : low_voltage_detect_control_bench

// *** tb/lvdc_props.sv ***
// Checker watching the supply monitor control block ports.
module lvdc_props (
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [3:0]                 wb_adr_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire logic                       warning_condition,
    input wire logic                       detect_event,
    input wire logic                       warning_irq,
    input wire logic                       detect_reset_req,
    input wire lvdc_pkg::lvdc_analog_ctl_t analog_ctl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Reads are remembered so that the answer can be tied to its request.
    logic rd_one;
    logic rd_two;
    always_ff @(posedge clk) begin
        rd_one <= wb_cyc_i & wb_stb_i & ~wb_we_i & (wb_adr_i == 4'h0);
        rd_two <= wb_cyc_i & wb_stb_i & ~wb_we_i & (wb_adr_i == 4'h4);
    end
    a_reset_cause: assert property (
        detect_reset_req |-> detect_event) else $error("reset without event");
    a_reset_gated: assert property (
        !analog_ctl.detect_on |-> !detect_reset_req) else $error("reset while off");
    a_two_reserved: assert property (
        wb_ack_o && rd_two |-> wb_dat_o[7] == 1'b0 && wb_dat_o[3:0] == 4'h0)
        else $error("reserved bits nonzero");
    a_trip_readback: assert property (
        wb_ack_o && rd_two |-> wb_dat_o[6] == analog_ctl.trip_high)
        else $error("trip select differs");
    a_level_readback: assert property (
        wb_ack_o && rd_two |-> wb_dat_o[5:4] == analog_ctl.warn_level)
        else $error("warning level differs");
    a_buffer_readback: assert property (
        wb_ack_o && rd_one |-> wb_dat_o[0] == analog_ctl.buf_on)
        else $error("buffer enable differs");
    a_irq_rise: assert property (
        $rose(warning_irq) |-> $past(warning_condition) || $past(wb_we_i & wb_stb_i))
        else $error("irq rose without cause");
    a_irq_fall: assert property (
        $fell(warning_irq) |-> $past(wb_we_i & wb_stb_i)) else $error("irq fell");
    c_irq: cover property ($rose(warning_irq));
    c_reset: cover property (detect_reset_req);
    c_two: cover property (wb_ack_o && rd_two);
endmodule : lvdc_props

bind lvdc_top lvdc_props u_props (
    .clk                (clk),
    .rst_b              (rst_b),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .warning_condition  (warning_condition),
    .detect_event       (detect_event),
    .warning_irq        (warning_irq),
    .detect_reset_req   (detect_reset_req),
    .analog_ctl         (analog_ctl)
);
